// ==== hdl/alarm_limits_bank.sv ====
// Purpose: Alarm limits, hysteresis, DAC clear and DAC activation registers
// Assumes: Byte register port, read data one cycle after the read strobe
// Notes: Alarm flags and DAC controls come straight from flip-flops
//
// What this block does
// - ADC lower limit: 12-bit unsigned from low byte and high-byte nibble.
// - Temperature upper limit: two's complement, resets to nibble 0x7, low 0xFF.
// - Temperature lower limit: two's complement, resets to nibble 0x8, low 0x00.
// - Each ADC channel and the temperature have their own hysteresis.
// - ADC hysteresis bits 6-0, one code per step, reset 0x08, bit 7 storage.
// - Temperature hysteresis bits 4-0, one degree per step; bits 7-5 reserved.
// - Clear bit at one forces that DAC into clear state.
// - Clear bit back at zero returns that DAC to its programmed code.
// - 0xB0 clears DACs 7-0, 0xB1 clears DACs 15-8; reset zero.
// - All activation bits reset to zero, components off.
// - Activation bit one powers the DAC; zero keeps it clamped.
// - 0xB2 holds activation bits for DACs 7-0, all read/write.
// - Outside the window sets alarm; upper not above lower always alarms.
// - ADC upper limit resets to low 0xFF and nibble 0xF.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "alarm_limits_cfg.svh"

module alarm_limits_bank
(
  input wire logic clk, // Device clock, 40 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input alarm_limits_pkg::reg_req_t req, // Register port request
  output logic [`DATA_W-1:0] rdData, // Read data, cycle after read
  input alarm_limits_pkg::adc_sample_t adcSample, // Unipolar ADC results
  input alarm_limits_pkg::temp_sample_t tempSample, // Temperature result
  output logic [`ADC_CHANNELS-1:0] adcAlarm, // Per-channel window alarm
  output logic tempAlarm, // Temperature window alarm
  output logic [`DAC_COUNT-1:0] dacForceClear, // DAC forced to clear state
  output logic [`DAC_COUNT-1:0] dacActivate // DAC powered, else clamped
);
  import alarm_limits_pkg::*;

  bank_state_t st_r;
  bank_state_t st_nxt;
  logic [`ADC_CHANNELS-1:0][`CODE_W-1:0] adcLowerLimit;
  logic [`ADC_CHANNELS-1:0][`CODE_W-1:0] adcUpperLimit;
  logic [`ADC_CHANNELS-1:0][`HYST_W-1:0] adcHystSteps;
  logic [`CODE_W-1:0] tempUpperLimit;
  logic [`CODE_W-1:0] tempLowerLimit;
  logic [`HYST_W-1:0] tempHystSteps;

  // ============================================================
  // Address helpers
  // ============================================================

  // Limit window covers five channels of four bytes each
  function automatic logic inAdcLimits(input logic [`ADDR_W-1:0] a);
    inAdcLimits = (a >= `ADC_LIMIT_FIRST) && (a <= `ADC_LIMIT_LAST);
  endfunction

  // Hysteresis window holds one byte per ADC channel
  function automatic logic inAdcHyst(input logic [`ADDR_W-1:0] a);
    inAdcHyst = (a >= `ADC_HYST_FIRST) && (a <= `ADC_HYST_LAST);
  endfunction

  // Channel of a limit byte; the window starts on a four-byte boundary
  function automatic logic [2:0] limitChannel(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] off;
    off = a - `ADC_LIMIT_FIRST;
    limitChannel = off[4:2];
  endfunction

  // Channel of a hysteresis byte, counted from the window start
  function automatic logic [2:0] hystChannel(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] off;
    off = a - `ADC_HYST_FIRST;
    hystChannel = off[2:0];
  endfunction

  // Twelve-bit limit from the low byte and the high nibble
  function automatic logic [`CODE_W-1:0] joinLimit(
    input logic [`DATA_W-1:0] lowByte,
    input logic [`DATA_W-1:0] highByte);
    joinLimit = {highByte[`LIMIT_NIBBLE_MSB:0], lowByte};
  endfunction

  // ============================================================
  // Register write and read decode
  // ============================================================

  // Writes store whole bytes; reserved bits are plain storage
  always_comb
  begin
    logic [2:0] ch;
    ch = 3'h0;
    st_nxt = st_r;
    st_nxt.rdData = 8'h00;
    // Write wins if both strobes come; the master never sends both
    if (req.wr)
    begin
      if (inAdcLimits(req.addr))
      begin
        ch = limitChannel(req.addr);
        // Byte select inside the channel's four-byte group
        if (req.addr[1:0] == `ADC_UPPER_LOW_SEL)
        begin
          st_nxt.adcUpperLow[ch] = req.wrData;
        end
        else if (req.addr[1:0] == `ADC_UPPER_HIGH_SEL)
        begin
          st_nxt.adcUpperHigh[ch] = req.wrData;
        end
        else if (req.addr[1:0] == `ADC_LOWER_LOW_SEL)
        begin
          st_nxt.adcLowerLow[ch] = req.wrData;
        end
        else
        begin
          st_nxt.adcLowerHigh[ch] = req.wrData;
        end
      end
      // Temperature limit bytes; only the low nibble of a high byte compares
      else if (req.addr == `TEMP_UPPER_LIMIT_LOW_ADDR)
      begin
        st_nxt.tempUpperLow = req.wrData;
      end
      else if (req.addr == `TEMP_UPPER_LIMIT_HIGH_ADDR)
      begin
        st_nxt.tempUpperHigh = req.wrData;
      end
      else if (req.addr == `TEMP_LOWER_LIMIT_LOW_ADDR)
      begin
        st_nxt.tempLowerLow = req.wrData;
      end
      else if (req.addr == `TEMP_LOWER_LIMIT_HIGH_ADDR)
      begin
        st_nxt.tempLowerHigh = req.wrData;
      end
      // Reserved hysteresis bits are stored and read back
      else if (inAdcHyst(req.addr))
      begin
        ch = hystChannel(req.addr);
        st_nxt.adcHyst[ch] = req.wrData;
      end
      else if (req.addr == `TEMP_ALARM_HYSTERESIS_ADDR)
      begin
        st_nxt.tempHyst = req.wrData;
      end
      // DAC controls act on the outputs the cycle after the write
      else if (req.addr == `DAC_FORCE_CLEAR_LO_ADDR)
      begin
        st_nxt.clearLo = req.wrData;
      end
      else if (req.addr == `DAC_FORCE_CLEAR_HI_ADDR)
      begin
        st_nxt.clearHi = req.wrData;
      end
      else if (req.addr == `DAC_ACTIVATE_LO_ADDR)
      begin
        st_nxt.activeLo = req.wrData;
      end
      else if (req.addr == `DAC_ACTIVATE_HI_ADDR)
      begin
        st_nxt.activeHi = req.wrData;
      end
    end
    else if (req.rd)
    begin
      // Unmapped offsets read as zero
      if (inAdcLimits(req.addr))
      begin
        ch = limitChannel(req.addr);
        // Same byte select as on the write side
        if (req.addr[1:0] == `ADC_UPPER_LOW_SEL)
        begin
          st_nxt.rdData = st_r.adcUpperLow[ch];
        end
        else if (req.addr[1:0] == `ADC_UPPER_HIGH_SEL)
        begin
          st_nxt.rdData = st_r.adcUpperHigh[ch];
        end
        else if (req.addr[1:0] == `ADC_LOWER_LOW_SEL)
        begin
          st_nxt.rdData = st_r.adcLowerLow[ch];
        end
        else
        begin
          st_nxt.rdData = st_r.adcLowerHigh[ch];
        end
      end
      // Whole bytes come back, reserved bits included
      else if (req.addr == `TEMP_UPPER_LIMIT_LOW_ADDR)
      begin
        st_nxt.rdData = st_r.tempUpperLow;
      end
      else if (req.addr == `TEMP_UPPER_LIMIT_HIGH_ADDR)
      begin
        st_nxt.rdData = st_r.tempUpperHigh;
      end
      else if (req.addr == `TEMP_LOWER_LIMIT_LOW_ADDR)
      begin
        st_nxt.rdData = st_r.tempLowerLow;
      end
      else if (req.addr == `TEMP_LOWER_LIMIT_HIGH_ADDR)
      begin
        st_nxt.rdData = st_r.tempLowerHigh;
      end
      else if (inAdcHyst(req.addr))
      begin
        ch = hystChannel(req.addr);
        st_nxt.rdData = st_r.adcHyst[ch];
      end
      else if (req.addr == `TEMP_ALARM_HYSTERESIS_ADDR)
      begin
        st_nxt.rdData = st_r.tempHyst;
      end
      // Control registers read back what the outputs show
      else if (req.addr == `DAC_FORCE_CLEAR_LO_ADDR)
      begin
        st_nxt.rdData = st_r.clearLo;
      end
      else if (req.addr == `DAC_FORCE_CLEAR_HI_ADDR)
      begin
        st_nxt.rdData = st_r.clearHi;
      end
      else if (req.addr == `DAC_ACTIVATE_LO_ADDR)
      begin
        st_nxt.rdData = st_r.activeLo;
      end
      else if (req.addr == `DAC_ACTIVATE_HI_ADDR)
      begin
        st_nxt.rdData = st_r.activeHi;
      end
    end
  end

  // ============================================================
  // State register with power-on values
  // ============================================================

  // Whole bank reloads on reset so no field keeps a stale value
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `ADC_CHANNELS; i++)
      begin
        // Every ADC channel starts with the widest window
        st_r.adcUpperLow[i] <= `ADC_UPPER_LOW_RST;
        st_r.adcUpperHigh[i] <= `ADC_UPPER_HIGH_RST;
        st_r.adcLowerLow[i] <= `ADC_LOWER_LOW_RST;
        st_r.adcLowerHigh[i] <= `ADC_LOWER_HIGH_RST;
        st_r.adcHyst[i] <= `ADC_HYST_RST;
      end
      st_r.tempUpperLow <= `TEMP_UPPER_LOW_RST;
      st_r.tempUpperHigh <= `TEMP_UPPER_HIGH_RST;
      st_r.tempLowerLow <= `TEMP_LOWER_LOW_RST;
      st_r.tempLowerHigh <= `TEMP_LOWER_HIGH_RST;
      st_r.tempHyst <= `TEMP_HYST_RST;
      st_r.clearLo <= `DAC_CTRL_RST;
      st_r.clearHi <= `DAC_CTRL_RST;
      st_r.activeLo <= `DAC_CTRL_RST;
      st_r.activeHi <= `DAC_CTRL_RST;
      st_r.rdData <= 8'h00;
    end
    else
    begin
      // Otherwise the whole bank follows the decode
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Limits and hysteresis as seen by the alarm checkers
  // ============================================================

  // Reserved bits above each field are kept but never reach compare
  always_comb
  begin
    for (int i = 0; i < `ADC_CHANNELS; i++)
    begin
      adcLowerLimit[i] = joinLimit(st_r.adcLowerLow[i], st_r.adcLowerHigh[i]);
      adcUpperLimit[i] = joinLimit(st_r.adcUpperLow[i], st_r.adcUpperHigh[i]);
      adcHystSteps[i] = st_r.adcHyst[i][`ADC_HYST_MSB:0];
    end
  end

  // Temperature bytes join the same way; the checker compares them signed
  assign tempUpperLimit = joinLimit(st_r.tempUpperLow, st_r.tempUpperHigh);
  assign tempLowerLimit = joinLimit(st_r.tempLowerLow, st_r.tempLowerHigh);
  // One degree per step equals one temperature code step here
  assign tempHystSteps = {2'b00, st_r.tempHyst[`TEMP_HYST_MSB:0]};

  // ============================================================
  // One checker per monitored channel, each with its own hysteresis
  // ============================================================

  // All five ADC checkers share one sample strobe
  for (genvar g = 0; g < `ADC_CHANNELS; g++)
  begin : gAdc
    alarm_window
    #(
      .SIGNED_CODE(1'b0)
    )
    uAdcAlarm
    (
      .clk(clk),
      .rst_n(rst_n),
      .sampleValid(adcSample.valid),
      .sample(adcSample.code[g]),
      .lower(adcLowerLimit[g]),
      .upper(adcUpperLimit[g]),
      .hyst(adcHystSteps[g]),
      .alarm(adcAlarm[g])
    );
  end

  // Temperature compares in two's complement
  alarm_window
  #(
    .SIGNED_CODE(1'b1)
  )
  uTempAlarm
  (
    .clk(clk),
    .rst_n(rst_n),
    .sampleValid(tempSample.valid),
    .sample(tempSample.code),
    .lower(tempLowerLimit),
    .upper(tempUpperLimit),
    .hyst(tempHystSteps),
    .alarm(tempAlarm)
  );

  // ============================================================
  // Outputs, all straight from flip-flops
  // ============================================================

  // Clear overrides the DAC code downstream; zero hands it back
  assign dacForceClear = {st_r.clearHi, st_r.clearLo};
  // Zero keeps the DAC clamped to save supply current
  assign dacActivate = {st_r.activeHi, st_r.activeLo};
  // Zero outside the cycle after a read
  assign rdData = st_r.rdData;

endmodule

// ==== hdl/alarm_limits_cfg.svh ====
// Purpose: Offsets, field positions, reset values and sizes of the limits bank
// Assumes: 8-bit register port, byte-wide registers
// Notes: Definitions only
`ifndef ALARM_LIMITS_CFG_SVH
`define ALARM_LIMITS_CFG_SVH

// ============================================================
// Sizes
`define ADC_CHANNELS 5
`define CODE_W 12
`define ADDR_W 8
`define DATA_W 8
`define DAC_COUNT 16

// ============================================================
// Register offsets
`define ADC_LIMIT_FIRST 8'h80
`define ADC_LIMIT_LAST 8'h93
`define ADC_UPPER_LOW_SEL 2'h0
`define ADC_UPPER_HIGH_SEL 2'h1
`define ADC_LOWER_LOW_SEL 2'h2
`define ADC_LOWER_HIGH_SEL 2'h3
`define TEMP_UPPER_LIMIT_LOW_ADDR 8'h94
`define TEMP_UPPER_LIMIT_HIGH_ADDR 8'h95
`define TEMP_LOWER_LIMIT_LOW_ADDR 8'h96
`define TEMP_LOWER_LIMIT_HIGH_ADDR 8'h97
`define ADC_HYST_FIRST 8'hA0
`define ADC_HYST_LAST 8'hA4
`define TEMP_ALARM_HYSTERESIS_ADDR 8'hA5
`define DAC_FORCE_CLEAR_LO_ADDR 8'hB0
`define DAC_FORCE_CLEAR_HI_ADDR 8'hB1
`define DAC_ACTIVATE_LO_ADDR 8'hB2
`define DAC_ACTIVATE_HI_ADDR 8'hB3

// ============================================================
// Reset values
`define ADC_UPPER_LOW_RST 8'hFF
`define ADC_UPPER_HIGH_RST 8'h0F
`define ADC_LOWER_LOW_RST 8'h00
`define ADC_LOWER_HIGH_RST 8'h00
`define ADC_HYST_RST 8'h08
`define TEMP_UPPER_LOW_RST 8'hFF
`define TEMP_UPPER_HIGH_RST 8'h07
`define TEMP_LOWER_LOW_RST 8'h00
`define TEMP_LOWER_HIGH_RST 8'h08
`define TEMP_HYST_RST 8'h08
`define DAC_CTRL_RST 8'h00

// ============================================================
// Field positions
`define LIMIT_NIBBLE_MSB 3
`define ADC_HYST_MSB 6
`define TEMP_HYST_MSB 4
`define HYST_W 7

`endif

// ==== hdl/alarm_limits_pkg.sv ====
// Purpose: Types shared by the limits bank and its alarm checker
// Assumes: alarm_limits_cfg.svh holds all numbers
// Notes: Structs carry grouped signals
`include "alarm_limits_cfg.svh"

package alarm_limits_pkg;

  // ============================================================
  // Register port request
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wrData;
    logic wr;
    logic rd;
  } reg_req_t;

  // ============================================================
  // Measurement samples
  typedef struct packed {
    logic valid;
    logic [`ADC_CHANNELS-1:0][`CODE_W-1:0] code;
  } adc_sample_t;

  typedef struct packed {
    logic valid;
    logic [`CODE_W-1:0] code;
  } temp_sample_t;

  // ============================================================
  // Register storage of the bank
  typedef struct packed {
    logic [`ADC_CHANNELS-1:0][`DATA_W-1:0] adcUpperLow;
    logic [`ADC_CHANNELS-1:0][`DATA_W-1:0] adcUpperHigh;
    logic [`ADC_CHANNELS-1:0][`DATA_W-1:0] adcLowerLow;
    logic [`ADC_CHANNELS-1:0][`DATA_W-1:0] adcLowerHigh;
    logic [`ADC_CHANNELS-1:0][`DATA_W-1:0] adcHyst;
    logic [`DATA_W-1:0] tempUpperLow;
    logic [`DATA_W-1:0] tempUpperHigh;
    logic [`DATA_W-1:0] tempLowerLow;
    logic [`DATA_W-1:0] tempLowerHigh;
    logic [`DATA_W-1:0] tempHyst;
    logic [`DATA_W-1:0] clearLo;
    logic [`DATA_W-1:0] clearHi;
    logic [`DATA_W-1:0] activeLo;
    logic [`DATA_W-1:0] activeHi;
    logic [`DATA_W-1:0] rdData;
  } bank_state_t;

  // Alarm checker state
  typedef struct packed {
    logic alarm;
  } alarm_state_t;

endpackage

// ==== hdl/alarm_window.sv ====
// Purpose: Window alarm with hysteresis for one measured channel
// Assumes: Sample, limits and hysteresis on the same clock
// Notes: SIGNED_CODE selects two's complement compare
`timescale 1ns/1ps
`include "alarm_limits_cfg.svh"

module alarm_window
#(
  parameter bit SIGNED_CODE = 1'b0
)
(
  input wire logic clk, // Device clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic sampleValid, // New measurement this cycle
  input wire logic [`CODE_W-1:0] sample, // Measurement code
  input wire logic [`CODE_W-1:0] lower, // Lower limit
  input wire logic [`CODE_W-1:0] upper, // Upper limit
  input wire logic [`HYST_W-1:0] hyst, // Hysteresis in code steps
  output logic alarm // Alarm flag, registered
);
  import alarm_limits_pkg::*;

  alarm_state_t st_r;
  alarm_state_t st_nxt;
  logic signed [`CODE_W+1:0] sampleX;
  logic signed [`CODE_W+1:0] lowerX;
  logic signed [`CODE_W+1:0] upperX;
  logic signed [`CODE_W+1:0] hystX;

  // ============================================================
  // Widen by two bits so limit plus hysteresis never wraps
  function automatic logic signed [`CODE_W+1:0] widen(input logic [`CODE_W-1:0] v);
    if (SIGNED_CODE)
    begin
      widen = {{2{v[`CODE_W-1]}}, v};
    end
    else
    begin
      widen = {2'b00, v};
    end
  endfunction

  assign sampleX = widen(sample);
  assign lowerX = widen(lower);
  assign upperX = widen(upper);
  assign hystX = {7'h00, hyst};

  // Alarm decision, checked only on a new sample
  always_comb
  begin
    st_nxt = st_r;
    if (sampleValid)
    begin
      if (upperX <= lowerX)
      begin
        st_nxt.alarm = 1'b1;
      end
      else if (sampleX < lowerX || sampleX > upperX)
      begin
        st_nxt.alarm = 1'b1;
      end
      else if (st_r.alarm && (sampleX < lowerX + hystX || sampleX > upperX - hystX))
      begin
        st_nxt.alarm = 1'b1;
      end
      else
      begin
        st_nxt.alarm = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign alarm = st_r.alarm;

endmodule

// ==== verification/alarm_limits_monitor.sv ====
// ============================================================
// Purpose: Port-level checks of the alarm limits bank
// Assumes: One clock, synchronous active-low reset
// Notes: Attached to the bank by the bind at the foot
`timescale 1ns/1ps
`include "alarm_limits_cfg.svh"

module alarm_limits_monitor
(
  input wire logic clk, // Device clock
  input wire logic rst_n, // Synchronous reset, active low
  input alarm_limits_pkg::reg_req_t req, // Register request
  input wire logic [`DATA_W-1:0] rdData, // Read data
  input alarm_limits_pkg::adc_sample_t adcSample, // ADC samples
  input alarm_limits_pkg::temp_sample_t tempSample, // Temperature sample
  input wire logic [`ADC_CHANNELS-1:0] adcAlarm, // ADC alarms
  input wire logic tempAlarm, // Temperature alarm
  input wire logic [`DAC_COUNT-1:0] dacForceClear, // Clear controls
  input wire logic [`DAC_COUNT-1:0] dacActivate // Activation controls
);
  import alarm_limits_pkg::*;

  // ============================================================
  // Register port and DAC controls
  default clocking cb
    @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Read data only in the cycle after a read
  property p_rd_idle;
    !req.rd |=> rdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  property p_clr_lo;
    req.wr && req.addr == 8'hB0 |=> dacForceClear[7:0] == $past(req.wrData);
  endproperty
  a_clr_lo: assert property (p_clr_lo) else $error("low clear byte wrong");

  property p_clr_hi;
    req.wr && req.addr == 8'hB1 |=> dacForceClear[15:8] == $past(req.wrData);
  endproperty
  a_clr_hi: assert property (p_clr_hi) else $error("high clear byte wrong");

  property p_act_lo;
    req.wr && req.addr == 8'hB2 |=> dacActivate[7:0] == $past(req.wrData);
  endproperty
  a_act_lo: assert property (p_act_lo) else $error("low activate byte wrong");

  // Read of 0xB2 must agree with the live low activate outputs
  property p_act_rd;
    req.rd && req.addr == 8'hB2 |=> rdData == dacActivate[7:0];
  endproperty
  a_act_rd: assert property (p_act_rd) else $error("activate readback differs");

  // No write to 0xB0..0xB3 leaves every control as it was
  property p_ctrl_hold;
    !(req.wr && req.addr[7:2] == 6'h2C) |=> $stable(dacForceClear) && $stable(dacActivate);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved unbidden");

  property p_ctrl_rst;
    $rose(rst_n) |-> dacForceClear == 16'h0000 && dacActivate == 16'h0000 && !tempAlarm;
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("outputs not reset");

  // Alarms only move on a valid sample
  property p_temp_hold;
    !tempSample.valid |=> $stable(tempAlarm);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temp alarm moved");

  property p_adc_hold;
    !adcSample.valid |=> $stable(adcAlarm);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("adc alarm moved");
endmodule

bind alarm_limits_bank alarm_limits_monitor chkInst
(
  .clk(clk), .rst_n(rst_n), .req(req), .rdData(rdData), .adcSample(adcSample),
  .tempSample(tempSample), .adcAlarm(adcAlarm), .tempAlarm(tempAlarm),
  .dacForceClear(dacForceClear), .dacActivate(dacActivate)
);

// ==== verification/tb_top.sv ====
// ============================================================
// Purpose: Self-checking bench of the alarm limits bank
// Assumes: Read data one cycle after the read strobe
// Notes: Register rows in a table, alarm cases by hand
`timescale 1ns/1ps
`include "alarm_limits_cfg.svh"

module tb_top;
  import alarm_limits_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t req = '0;
  adc_sample_t adcSample = '0;
  temp_sample_t tempSample = '0;
  logic [7:0] rdData;
  logic [4:0] adcAlarm;
  logic tempAlarm;
  logic [15:0] dacForceClear;
  logic [15:0] dacActivate;
  logic [7:0] rdVal;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  // Rows: address, reset value, write value, readback value
  logic [31:0] rows [18] = '{32'h94FF3C3C, 32'h9507A5A5, 32'h9600C3C3, 32'h97085F5F,
    32'hA508E7E7, 32'hB0008181, 32'hB1007E7E, 32'hB2000F0F, 32'hB300F0F0, 32'h80FF1212,
    32'h810FF3F3, 32'h82003434, 32'h8300F1F1, 32'h93000A0A, 32'hA0088080, 32'hA4087F7F,
    32'hC0005A00, 32'h7F001100};

  alarm_limits_bank DUT
  (
    .clk(clk), .rst_n(rst_n), .req(req), .rdData(rdData), .adcSample(adcSample),
    .tempSample(tempSample), .adcAlarm(adcAlarm), .tempAlarm(tempAlarm),
    .dacForceClear(dacForceClear), .dacActivate(dacActivate)
  );

  // ============================================================
  // Clock, timeout and shared tasks
  always #12.5 clk = ~clk;

  // Ceiling well above the roughly two hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Data lands at the edge that takes the read; sample just after it
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 rdVal = rdData;
  endtask

  task automatic tsamp(input logic [11:0] c, input logic e);
    @(posedge clk);
    tempSample <= '{valid: 1'b1, code: c};
    @(posedge clk);
    tempSample.valid <= 1'b0;
    #1 chk("tempAlarm", {15'h0000, tempAlarm}, {15'h0000, e});
  endtask

  // Channels 1..4 sit mid-scale, inside their reset window
  task automatic asamp(input logic [11:0] c, input logic [4:0] e);
    @(posedge clk);
    adcSample <= {1'b1, {4{12'h800}}, c};
    @(posedge clk);
    adcSample.valid <= 1'b0;
    #1 chk("adcAlarm", {11'h000, adcAlarm}, {11'h000, e});
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      rd(rows[i][31:24]);
      chk($sformatf("reset %h", rows[i][31:24]), {8'h00, rdVal}, {8'h00, rows[i][23:16]});
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24]);
      chk($sformatf("readback %h", rows[i][31:24]), {8'h00, rdVal}, {8'h00, rows[i][7:0]});
    end
    chk("dacForceClear", dacForceClear, 16'h7E81);
    chk("dacActivate", dacActivate, 16'hF00F);
    // Write then read with no gap, then idle read data
    @(posedge clk);
    req <= '{addr: 8'hB2, wrData: 8'h5A, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: 8'hB2, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk("back-to-back read", {8'h00, rdData}, 16'h005A);
    @(posedge clk);
    #1 chk("idle rdData", {8'h00, rdData}, 16'h0000);
    wr(8'hB0, 8'h00);
    #1 chk("dacForceClear", dacForceClear, 16'h7E00);
    wr(8'hB0, 8'h01);
    #1 chk("dacForceClear", dacForceClear, 16'h7E01);
    // Reset in mid-run clears every control
    do_reset();
    #1 chk("dacForceClear", dacForceClear, 16'h0000);
    chk("dacActivate", dacActivate, 16'h0000);
    // Temperature window -16..16, hysteresis 4; upper bits are storage only
    wr(8'h94, 8'h10);
    wr(8'h95, 8'hF0);
    wr(8'h96, 8'hF0);
    wr(8'h97, 8'h0F);
    wr(8'hA5, 8'hE4);
    tsamp(12'h011, 1'b1);
    tsamp(12'h00E, 1'b1);
    tsamp(12'h00C, 1'b0);
    tsamp(12'hFEF, 1'b1);
    tsamp(12'hFF8, 1'b0);
    tsamp(12'h010, 1'b0);
    wr(8'h94, 8'hF0);
    wr(8'h95, 8'h0F);
    tsamp(12'hFF0, 1'b1);
    // Channel 0 lower limit 0x100, hysteresis 8 with bit 7 set
    wr(8'h83, 8'hF1);
    wr(8'hA0, 8'h88);
    asamp(12'h0FF, 5'h01);
    asamp(12'h105, 5'h01);
    asamp(12'h108, 5'h00);
    asamp(12'hFFF, 5'h00);
    // Channel 0 upper limit 0x800: upper edge and its hysteresis
    wr(8'h80, 8'h00);
    wr(8'h81, 8'h08);
    asamp(12'h801, 5'h01);
    asamp(12'h7FA, 5'h01);
    asamp(12'h7F8, 5'h00);
    summarize();
  end
endmodule
